// >>> hw/prox_threshold_irq.sv
// Threshold and data-ready interrupt logic with its byte registers.
// Assumes an I2C slave on the same clock gives one-cycle byte strobes.
// Contract
// R1: Persistence code selects 1..128 consecutive results
// R2: Low threshold in two bytes, high first
// R3: High threshold in two bytes, high first
// R4: Data-ready sets status bit 3
// R5: Below-low crossing sets status bit 1
// R6: Above-high crossing sets status bit 0
// R7: Flags sticky; write one clears, zero keeps
// R8: Interrupt pad low while any flag set
// R9: Enables gate flags; select 0 means proximity
// R10: Inside-window result restarts consecutive count
// R11: 16-bit result readable as two bytes
// R12: Register pointer advances after each byte
`timescale 1ns/10ps
`default_nettype none
module prox_threshold_irq (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic i_RESULT_VALID,
  input wire logic [15:0] i_RESULT,
  input wire logic i_ADDR_LOAD,
  input wire logic [7:0] i_ADDR,
  input wire logic i_WR_STB,
  input wire logic [7:0] i_WR_DATA,
  input wire logic i_RD_STB,
  output logic [7:0] o_RD_DATA,
  output logic [7:0] o_PTR,
  output logic o_INT_N
);
  logic [7:0] ptr;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [15:0] low_reg;
  logic [15:0] low_next;
  logic [15:0] high_reg;
  logic [15:0] high_next;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic int_n_reg;
  logic int_n_next;
  logic above_reg;
  logic above_next;
  logic below_reg;
  logic below_next;
  logic sample_reg;
  logic sample_next;
  logic fire;
  logic [7:0] rd_mux;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic use_prox;

  prox_regptr u_ptr (
    .i_clock(I_CLOCK),
    .i_rst(I_RST),
    .i_load(i_ADDR_LOAD),
    .i_addr(i_ADDR),
    .i_step(i_WR_STB | i_RD_STB), // R12
    .o_ptr(ptr)
  );

  prox_persist #(
    .CNT_W(8)
  ) u_persist (
    .i_clock(I_CLOCK),
    .i_rst(I_RST),
    .i_sample(sample_reg),
    .i_out_window(above_reg | below_reg), // R10
    .i_persist_code(ctrl_reg[prox_irq_pkg::CTRL_PERSIST_LSB +: prox_irq_pkg::CTRL_PERSIST_W]),
    .o_fire(fire)
  );

  // Register writes and result capture
  always_comb begin
    ctrl_next = ctrl_reg;
    low_next = low_reg;
    high_next = high_reg;
    result_next = result_reg;
    if (i_RESULT_VALID) begin
      result_next = i_RESULT; // R11
    end
    if (i_WR_STB) begin
      case (ptr)
        prox_irq_pkg::ADDR_IRQ_CTRL: ctrl_next = i_WR_DATA & prox_irq_pkg::CTRL_WMASK;
        prox_irq_pkg::ADDR_LOW_HI: low_next[15:8] = i_WR_DATA; // R2
        prox_irq_pkg::ADDR_LOW_LO: low_next[7:0] = i_WR_DATA; // R2
        prox_irq_pkg::ADDR_HIGH_HI: high_next[15:8] = i_WR_DATA; // R3
        prox_irq_pkg::ADDR_HIGH_LO: high_next[7:0] = i_WR_DATA; // R3
        default: ;
      endcase
    end
  end

  // Comparison stage: registered on the same edge that captures the result
  always_comb begin
    use_prox = ~ctrl_reg[prox_irq_pkg::CTRL_SRC_SEL_BIT]; // R9
    sample_next = i_RESULT_VALID & use_prox;
    above_next = above_reg;
    below_next = below_reg;
    if (i_RESULT_VALID) begin
      above_next = i_RESULT > high_reg; // R10
      below_next = i_RESULT < low_reg; // R10
    end
  end

  // Status flags; a set in the same cycle as a clear wins
  always_comb begin
    set_bits = prox_irq_pkg::ZERO_BYTE;
    if (sample_reg && fire == 1'b0) begin
      set_bits = prox_irq_pkg::ZERO_BYTE;
    end
    if (fire && ctrl_reg[prox_irq_pkg::CTRL_LIMIT_EN_BIT]) begin // R9
      set_bits[prox_irq_pkg::FLAG_HIGH_BIT] = above_reg; // R6
      set_bits[prox_irq_pkg::FLAG_LOW_BIT] = below_reg; // R5
    end
    if (i_RESULT_VALID && ctrl_reg[prox_irq_pkg::CTRL_READY_EN_BIT]) begin // R9
      set_bits[prox_irq_pkg::FLAG_READY_BIT] = 1'b1; // R4
    end
    clr_bits = prox_irq_pkg::ZERO_BYTE;
    if (i_WR_STB && ptr == prox_irq_pkg::ADDR_IRQ_FLAGS) begin
      clr_bits = i_WR_DATA; // R7
    end
    flags_next = ((flags_reg & ~clr_bits) | set_bits) & prox_irq_pkg::FLAGS_MASK; // R7
    int_n_next = ~(|flags_next); // R8
  end

  // Read data follows the pointer; registered so the output is a flop
  always_comb begin
    case (ptr)
      prox_irq_pkg::ADDR_RESULT_HI: rd_mux = result_reg[15:8]; // R11
      prox_irq_pkg::ADDR_RESULT_LO: rd_mux = result_reg[7:0]; // R11
      prox_irq_pkg::ADDR_IRQ_CTRL: rd_mux = ctrl_reg;
      prox_irq_pkg::ADDR_LOW_HI: rd_mux = low_reg[15:8];
      prox_irq_pkg::ADDR_LOW_LO: rd_mux = low_reg[7:0];
      prox_irq_pkg::ADDR_HIGH_HI: rd_mux = high_reg[15:8];
      prox_irq_pkg::ADDR_HIGH_LO: rd_mux = high_reg[7:0];
      prox_irq_pkg::ADDR_IRQ_FLAGS: rd_mux = flags_reg;
      default: rd_mux = prox_irq_pkg::ZERO_BYTE;
    endcase
    rd_data_next = rd_mux;
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_reg <= prox_irq_pkg::CTRL_RESET; // R1
      low_reg <= prox_irq_pkg::LOW_RESET;
      high_reg <= prox_irq_pkg::HIGH_RESET;
      result_reg <= 16'h0000;
      flags_reg <= prox_irq_pkg::ZERO_BYTE;
      rd_data_reg <= prox_irq_pkg::ZERO_BYTE;
      int_n_reg <= 1'b1;
      above_reg <= 1'b0;
      below_reg <= 1'b0;
      sample_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      low_reg <= low_next;
      high_reg <= high_next;
      result_reg <= result_next;
      flags_reg <= flags_next;
      rd_data_reg <= rd_data_next;
      int_n_reg <= int_n_next;
      above_reg <= above_next;
      below_reg <= below_next;
      sample_reg <= sample_next;
    end
  end

  assign o_RD_DATA = rd_data_reg;
  assign o_PTR = ptr;
  assign o_INT_N = int_n_reg;
endmodule : prox_threshold_irq
`default_nettype wire

// >>> hw/prox_irq_pkg.sv
// Constants for the proximity threshold interrupt block.
// Assumes an I2C slave elsewhere delivers byte register accesses.
package prox_irq_pkg;
  localparam logic [7:0] ADDR_RESULT_HI = 8'h87;
  localparam logic [7:0] ADDR_RESULT_LO = 8'h88;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h89;
  localparam logic [7:0] ADDR_LOW_HI = 8'h8A;
  localparam logic [7:0] ADDR_LOW_LO = 8'h8B;
  localparam logic [7:0] ADDR_HIGH_HI = 8'h8C;
  localparam logic [7:0] ADDR_HIGH_LO = 8'h8D;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h8E;
  // Control field positions
  localparam int CTRL_SRC_SEL_BIT = 0;
  localparam int CTRL_LIMIT_EN_BIT = 1;
  localparam int CTRL_READY_EN_BIT = 3;
  localparam int CTRL_PERSIST_LSB = 5;
  localparam int CTRL_PERSIST_W = 3;
  // Flag positions
  localparam int FLAG_HIGH_BIT = 0;
  localparam int FLAG_LOW_BIT = 1;
  localparam int FLAG_READY_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hEB;
  localparam logic [7:0] FLAGS_MASK = 8'h0B;
  localparam logic [15:0] LOW_RESET = 16'h0000;
  localparam logic [15:0] HIGH_RESET = 16'hFFFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : prox_irq_pkg

// >>> hw/prox_persist.sv
// Consecutive out-of-window counter for threshold events.
// Assumes one sample pulse per finished measurement, same clock.
`timescale 1ns/10ps
`default_nettype none
module prox_persist #(
  parameter int CNT_W = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_sample,
  input wire logic i_out_window,
  input wire logic [2:0] i_persist_code,
  output logic o_fire
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic fire_reg;
  logic fire_next;
  logic [CNT_W:0] need;
  logic [CNT_W:0] count_inc;

  always_comb begin
    need = (CNT_W+1)'(1) << i_persist_code; // R1
    count_inc = {1'b0, count_reg} + (CNT_W+1)'(1);
    count_next = count_reg;
    fire_next = 1'b0;
    if (i_sample) begin
      if (!i_out_window) begin
        count_next = '0; // R10
      end else if (count_inc >= need) begin
        // Stays saturated so each further outside result keeps firing
        fire_next = 1'b1; // R1
        count_next = (count_inc > need) ? count_reg : count_inc[CNT_W-1:0];
      end else begin
        count_next = count_inc[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= '0;
      fire_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      fire_reg <= fire_next;
    end
  end

  assign o_fire = fire_reg;
endmodule : prox_persist
`default_nettype wire

// >>> hw/prox_regptr.sv
// Register pointer with auto-increment after each byte access.
// Assumes the I2C slave pulses load on the address byte, step per data byte.
`timescale 1ns/10ps
`default_nettype none
module prox_regptr (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [7:0] i_addr,
  input wire logic i_step,
  output logic [7:0] o_ptr
);
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;

  always_comb begin
    ptr_next = ptr_reg;
    if (i_load) begin
      ptr_next = i_addr;
    end else if (i_step) begin
      ptr_next = ptr_reg + 8'h01; // R12
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ptr_reg <= 8'h00;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  assign o_ptr = ptr_reg;
endmodule : prox_regptr
`default_nettype wire

// >>> tb/prox_chk_props.sv
// Port checker for the threshold interrupt block.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module prox_chk (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic i_RESULT_VALID,
  input wire logic [15:0] i_RESULT,
  input wire logic i_ADDR_LOAD,
  input wire logic [7:0] i_ADDR,
  input wire logic i_WR_STB,
  input wire logic [7:0] i_WR_DATA,
  input wire logic i_RD_STB,
  input wire logic [7:0] o_RD_DATA,
  input wire logic [7:0] o_PTR,
  input wire logic o_INT_N
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // Four quiet cycles: no threshold or ready set can still be in flight
  sequence s_quiet;
    !i_RESULT_VALID [*4];
  endsequence
  sequence s_clr_all;
    i_WR_STB && o_PTR == 8'h8E && i_WR_DATA[3] && (&i_WR_DATA[1:0]);
  endsequence
  AST_LOAD: assert property (i_ADDR_LOAD |=> o_PTR == $past(i_ADDR))
    else $error("pointer load");
  AST_STEP: assert property ((i_RD_STB || i_WR_STB) && !i_ADDR_LOAD
    |=> o_PTR == $past(o_PTR) + 8'h01) else $error("pointer step");
  AST_HOLD: assert property (!(i_RD_STB || i_WR_STB || i_ADDR_LOAD) |=> $stable(o_PTR))
    else $error("pointer moved");
  AST_STICKY: assert property (!o_INT_N && !i_WR_STB |=> !o_INT_N)
    else $error("pad released");
  AST_CAUSE: assert property ($fell(o_INT_N) |-> $past(i_RESULT_VALID) ||
    $past(i_RESULT_VALID, 2) || $past(i_RESULT_VALID, 3) || $past(i_RESULT_VALID, 4))
    else $error("pad low without result");
  AST_RISE: assert property ($rose(o_INT_N) |-> $past(i_WR_STB) && $past(o_PTR) == 8'h8E)
    else $error("pad high without clear");
  AST_CLEAR: assert property (s_quiet ##0 s_clr_all |=> o_INT_N)
    else $error("pad low after full clear");
  AST_FLAGBITS: assert property (o_PTR == 8'h8E [*3] |-> (o_RD_DATA & 8'hF4) == 8'h00)
    else $error("spare flag bits");
endmodule : prox_chk
bind prox_threshold_irq prox_chk chk_u (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
  .i_RESULT_VALID(i_RESULT_VALID), .i_RESULT(i_RESULT), .i_ADDR_LOAD(i_ADDR_LOAD),
  .i_ADDR(i_ADDR), .i_WR_STB(i_WR_STB), .i_WR_DATA(i_WR_DATA), .i_RD_STB(i_RD_STB),
  .o_RD_DATA(o_RD_DATA), .o_PTR(o_PTR), .o_INT_N(o_INT_N));
`default_nettype wire

// >>> tb/host_model.sv
// Host side: byte accesses as the bus slave hands them on, and results.
// Drives at falling edges; released lines show the inverse of last value.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_vld,
  output logic [15:0] o_res,
  output logic o_ld,
  output logic [7:0] o_adr,
  output logic o_wr,
  output logic [7:0] o_wd,
  output logic o_rd
);
  // Idle levels set once here, so no port is bound to a fixed value
  initial begin
    o_vld = 1'b0;
    o_res = 16'h0000;
    o_ld = 1'b0;
    o_adr = 8'h00;
    o_wr = 1'b0;
    o_wd = 8'h00;
    o_rd = 1'b0;
  end
  task automatic seek(input logic [7:0] a);
    @(negedge i_clk);
    o_ld = 1'b1;
    o_adr = a;
    @(negedge i_clk);
    o_ld = 1'b0;
    o_adr = ~a;
  endtask : seek
  task automatic put(input logic [7:0] d);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_wd = d;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wd = ~d;
  endtask : put
  // Next byte comes from the stepped pointer, no new address needed
  task automatic get(output logic [7:0] d);
    repeat (2) @(negedge i_clk);
    d = i_rdata;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
  endtask : get
  task automatic feed(input logic [15:0] r);
    @(negedge i_clk);
    o_vld = 1'b1;
    o_res = r;
    @(negedge i_clk);
    o_vld = 1'b0;
    o_res = ~r;
  endtask : feed
endmodule : host_model
`default_nettype wire

// >>> tb/prox_threshold_irq_tb_top.sv
// Self-checking bench for the threshold interrupt block.
// Host model drives strobes and results; bench only sequences and checks.
`timescale 1ns/10ps
`default_nettype none
module prox_threshold_irq_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld, ld, wr, rd, int_n;
  logic [15:0] res;
  logic [7:0] adr, wd, rdata, ptr, b;
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  logic [7:0] th [4] = '{8'h01, 8'h00, 8'h02, 8'h00};
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  host_model host_u (.i_clk(clk), .i_rdata(rdata), .o_vld(vld), .o_res(res), .o_ld(ld),
    .o_adr(adr), .o_wr(wr), .o_wd(wd), .o_rd(rd));
  prox_threshold_irq dut_u (.I_CLOCK(clk), .I_RST(rst), .i_RESULT_VALID(vld), .i_RESULT(res),
    .i_ADDR_LOAD(ld), .i_ADDR(adr), .i_WR_STB(wr), .i_WR_DATA(wd), .i_RD_STB(rd),
    .o_RD_DATA(rdata), .o_PTR(ptr), .o_INT_N(int_n));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // Run is about 500 cycles; a hang stops well before the overall budget
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_at(input logic [7:0] a, input logic [7:0] exp);
    host_u.seek(a);
    host_u.get(b);
    chk(b, exp);
  endtask : rd_at
  task automatic wr_at(input logic [7:0] a, input logic [7:0] d);
    host_u.seek(a);
    host_u.put(d);
  endtask : wr_at
  // Waits out the result pipeline, then reads the flags and the pad
  task automatic flags(input logic [7:0] exp);
    repeat (5) @(negedge clk);
    rd_at(8'h8E, exp);
    chk({7'h00, int_n}, {7'h00, exp == 8'h00});
  endtask : flags
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    host_u.seek(8'h89);
    for (int i = 0; i < 6; i++) begin
      host_u.get(b);
      chk(b, rv[i]);
    end
    chk(ptr, 8'h8F);
    host_u.seek(8'h8A);
    for (int i = 0; i < 4; i++) begin
      host_u.put(th[i]);
    end
    host_u.seek(8'h8A);
    for (int i = 0; i < 4; i++) begin
      host_u.get(b);
      chk(b, th[i]);
    end
    rd_at(8'h90, 8'h00);
    wr_at(8'h89, 8'hFF);
    rd_at(8'h89, 8'hEB);
    wr_at(8'h89, 8'h08);
    host_u.feed(16'h0150);
    flags(8'h08);
    wr_at(8'h8E, 8'h00);
    flags(8'h08);
    wr_at(8'h8E, 8'h08);
    flags(8'h00);
    wr_at(8'h89, 8'h22);
    host_u.feed(16'h0300);
    host_u.feed(16'h0150);
    host_u.feed(16'h0300);
    flags(8'h00);
    host_u.feed(16'h0300);
    flags(8'h01);
    rd_at(8'h87, 8'h03);
    host_u.get(b);
    chk(b, 8'h00);
    wr_at(8'h8E, 8'h0B);
    flags(8'h00);
    host_u.feed(16'h0150);
    host_u.feed(16'h0050);
    flags(8'h00);
    host_u.feed(16'h0050);
    flags(8'h02);
    wr_at(8'h89, 8'h23);
    wr_at(8'h8E, 8'h02);
    repeat (3) host_u.feed(16'h0300);
    flags(8'h00);
    wr_at(8'h89, 8'hE2);
    host_u.feed(16'h0150);
    repeat (127) host_u.feed(16'h0300);
    flags(8'h00);
    host_u.feed(16'h0300);
    flags(8'h01);
    end_of_test();
  end
endmodule : prox_threshold_irq_tb_top
`default_nettype wire
